// ===== inc/i2c_pkg.sv
// Constants shared by the two-wire status and data path.
// Assumes a 32-bit APB slave with byte addresses in the low eight bits.
package i2c_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_OWN = 8'h04;
	localparam logic [7:0] OFF_TX = 8'h08;
	localparam logic [7:0] OFF_RX = 8'h0C;
	localparam logic [7:0] OFF_CTRL = 8'h10;

	localparam int BIT_RECEIVE_FULL_FLAG = 5;
	localparam int BIT_NACK = 4;
	localparam int BIT_STOP = 3;
	localparam int BIT_AL = 2;
	localparam int BIT_AAS = 1;
	localparam int BIT_ADZ = 0;

	localparam int BIT_FS = 0;

	localparam int CTRL_MST = 0;
	localparam int CTRL_TRS = 1;
	localparam int CTRL_ACK_CHECK_ENABLE = 2;
	localparam int CTRL_MLS = 3;
	localparam int CTRL_ACKBT = 4;

	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_OWN = 8'h00;
	localparam logic [7:0] RST_TX = 8'hFF;
	localparam logic [7:0] RST_RX = 8'hFF;
	localparam logic [7:0] RST_CTRL = 8'h00;

	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam logic FMT_TWO_WIRE = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b100
	} frame_state_t;

endpackage

// ===== inc/shift_if.sv
// Link between the register core and the bit shifting engine.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface shift_if;
	logic load;
	logic [7:0] load_data;
	logic tx_en;
	logic sync_fmt;
	logic ack_drive_en;
	logic ack_level;
	logic restart;
	logic scl_rise;
	logic scl_fall;
	logic sda_in;
	logic empty;
	logic byte_done;
	logic ack_done;
	logic ack_bit;
	logic [7:0] rx_byte;
	logic sda_level;
	logic drive;
	logic in_data;

	modport core (
		output load, load_data, tx_en, sync_fmt, ack_drive_en, ack_level, restart,
		output scl_rise, scl_fall, sda_in,
		input empty, byte_done, ack_done, ack_bit, rx_byte, sda_level, drive, in_data
	);
	modport engine (
		input load, load_data, tx_en, sync_fmt, ack_drive_en, ack_level, restart,
		input scl_rise, scl_fall, sda_in,
		output empty, byte_done, ack_done, ack_bit, rx_byte, sda_level, drive, in_data
	);
endinterface // shift_if

// ===== logic/bit_shifter.sv
// Serial shift engine: eight data bits, plus an acknowledge slot unless sync_fmt is set.
// Assumes clock edges arrive as one-cycle pulses on pclk.
`timescale 1ns/1ps
module bit_shifter (
	input wire logic pclk,
	input wire logic presetn,
	shift_if.engine bus
);
	import i2c_pkg::*;

	logic [7:0] shift_reg;
	logic [3:0] count_reg;

	// Bit counter and serial capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_reg <= RST_TX;
			count_reg <= 4'h0;
			bus.empty <= 1'b1;
			bus.byte_done <= 1'b0;
			bus.ack_done <= 1'b0;
			bus.ack_bit <= 1'b0;
			bus.rx_byte <= RST_RX;
		end else begin
			bus.byte_done <= 1'b0;
			bus.ack_done <= 1'b0;
			if (bus.restart) begin
				count_reg <= 4'h0;
			end else if (bus.scl_rise && count_reg == ACK_SLOT) begin
				bus.ack_bit <= bus.sda_in;
				bus.ack_done <= 1'b1;
				count_reg <= 4'h0;
				bus.empty <= 1'b1;
			end else if (bus.scl_rise) begin
				shift_reg <= {shift_reg[6:0], bus.sda_in};
				count_reg <= count_reg + 4'h1;
				if (count_reg == LAST_DATA_BIT) begin
					bus.byte_done <= 1'b1;
					bus.rx_byte <= {shift_reg[6:0], bus.sda_in};
					if (bus.sync_fmt) begin
						count_reg <= 4'h0;
						bus.empty <= 1'b1;
					end
				end
			end
			if (bus.load && bus.empty) begin
				shift_reg <= bus.load_data;
				bus.empty <= 1'b0;
			end
		end
	end

	// Output bit changes only while the clock is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.sda_level <= 1'b1;
			bus.drive <= 1'b0;
		end else if (bus.scl_fall && count_reg == ACK_SLOT) begin
			bus.sda_level <= bus.ack_level;
			bus.drive <= bus.ack_drive_en & ~bus.tx_en;
		end else if (bus.scl_fall) begin
			bus.sda_level <= shift_reg[7];
			bus.drive <= bus.tx_en & ~bus.empty;
		end
	end

	assign bus.in_data = (count_reg != ACK_SLOT);
endmodule // bit_shifter

// ===== logic/cond_detect.sv
// Pin synchroniser with clock edge and start/stop detection.
// Assumes scl and sda pins are asynchronous to pclk.
`timescale 1ns/1ps
module cond_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic scl_s,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	logic scl_meta_reg;
	logic sda_meta_reg;
	logic scl_d_reg;
	logic sda_d_reg;

	// Two-stage synchroniser, then one delay stage for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_meta_reg <= 1'b1;
			sda_meta_reg <= 1'b1;
			scl_s <= 1'b1;
			sda_s <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_meta_reg <= scl_pin;
			sda_meta_reg <= sda_pin;
			scl_s <= scl_meta_reg;
			sda_s <= sda_meta_reg;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
endmodule // cond_detect

// ===== logic/i2c_status_path.sv
// Two-wire status flags, own address, and transmit/receive data path.
// Assumes an APB master on pclk and open-drain scl/sda pins outside.
// Functional notes
// [RULE1] No acknowledge while checking sets bit 4
// [RULE2] Flags clear by zero write after read
// [RULE3] Stop after a frame sets bit 3
// [RULE4] Master transmit data mismatch loses arbitration
// [RULE5] Driving high during start loses arbitration
// [RULE6] Synchronous format: receive while full overruns
// [RULE7] Own address match in slave receive
// [RULE8] General call also sets address match
// [RULE9] General call flag, slave receive two-wire
// [RULE10] Compare upper seven bits with own address
// [RULE11] Own address bit 0 selects format
// [RULE12] Free shift register loads holding byte
// [RULE13] Early next byte keeps transfer gapless
// [RULE14] Bit order select reverses holding readback
// [RULE15] Full byte moves to receive holding
// [RULE16] Receive holding ignores CPU writes
// [RULE17] Shift register drives data pin serially
// [RULE18] Shift register not readable by CPU
// [RULE19] Moving received byte sets receive full
// [RULE20] Acknowledge check halts on missing acknowledge
// [RULE21] Unarmed clear ignored; set beats clear
// [RULE22] General call is all-zero first frame
`timescale 1ns/1ps
module i2c_status_path (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [i2c_pkg::ADDR_W-1:0] paddr,
	input wire logic [i2c_pkg::DATA_W-1:0] pwdata,
	output logic [i2c_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import i2c_pkg::*;

	function automatic logic [7:0] bit_reverse(input logic [7:0] d);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = d[7 - i];
		end
		return r;
	endfunction

	function automatic logic decode_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [7:0] armed_reg;
	logic [7:0] own_address_reg;
	logic [7:0] transmit_holding_reg;
	logic [7:0] receive_holding_reg;
	logic [7:0] ctrl_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic tx_pending_reg;
	logic addressed_reg;
	logic frame_seen_reg;
	logic sda_oe_reg;
	frame_state_t state_reg;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	logic setup;
	logic access;
	logic mapped;
	logic wr_status;
	logic wr_own;
	logic wr_tx;
	logic wr_ctrl;
	logic rd_status;
	logic rd_rx;
	logic two_wire;
	logic mst;
	logic trs;
	logic ack_check_enable;
	logic bit_order_select;
	logic slave_rx;
	logic first_frame;
	logic own_hit;
	logic gcall;
	logic rx_take;
	logic ev_nack;
	logic ev_stop;
	logic ev_al;
	logic ev_ove;
	logic ev_aas;
	logic ev_adz;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;

	shift_if sif ();

	cond_detect u_cond (
		.pclk(pclk),
		.presetn(presetn),
		.scl_pin(scl_in),
		.sda_pin(sda_in),
		.scl_s(scl_s),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	bit_shifter u_shift (
		.pclk(pclk),
		.presetn(presetn),
		.bus(sif.engine)
	);

	// APB decode, zero wait states
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign mapped = decode_hit(paddr, OFF_STATUS) | decode_hit(paddr, OFF_OWN)
		| decode_hit(paddr, OFF_TX) | decode_hit(paddr, OFF_RX) | decode_hit(paddr, OFF_CTRL);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_reg;
	assign wr_status = access & pwrite & decode_hit(paddr, OFF_STATUS);
	assign wr_own = access & pwrite & decode_hit(paddr, OFF_OWN);
	assign wr_tx = access & pwrite & decode_hit(paddr, OFF_TX);
	assign wr_ctrl = access & pwrite & decode_hit(paddr, OFF_CTRL);
	assign rd_status = access & ~pwrite & decode_hit(paddr, OFF_STATUS);
	assign rd_rx = access & ~pwrite & decode_hit(paddr, OFF_RX);

	// Mode decode
	assign two_wire = (own_address_reg[BIT_FS] == FMT_TWO_WIRE); // [RULE11]
	assign mst = ctrl_reg[CTRL_MST];
	assign trs = ctrl_reg[CTRL_TRS];
	assign ack_check_enable = ctrl_reg[CTRL_ACK_CHECK_ENABLE];
	assign bit_order_select = ctrl_reg[CTRL_MLS];
	assign slave_rx = two_wire & ~mst & ~trs;

	// First frame after start: address compare
	assign first_frame = (state_reg == ST_ADDR) & sif.byte_done;
	assign own_hit = (sif.rx_byte[7:1] == own_address_reg[7:1]); // [RULE10]
	assign gcall = (sif.rx_byte == {GCALL_ADDR, 1'b0}); // [RULE22]
	assign ev_aas = first_frame & slave_rx & (own_hit | gcall); // [RULE7] [RULE8]
	assign ev_adz = first_frame & slave_rx & gcall; // [RULE9]

	// Flag events
	assign ev_nack = sif.ack_done & trs & ack_check_enable & sif.ack_bit; // [RULE1]
	assign ev_stop = stop_det & frame_seen_reg; // [RULE3]
	assign ev_al = two_wire & mst & ((scl_rise & trs & sif.drive & sif.in_data
		& (sif.sda_level != sda_s)) // [RULE4]
		| (start_det & sif.drive & sif.sda_level)); // [RULE5]
	assign ev_ove = ~two_wire & sif.byte_done & ~trs & status_reg[BIT_RECEIVE_FULL_FLAG]; // [RULE6]
	assign rx_take = sif.byte_done & ~trs & (~two_wire | mst | addressed_reg | ev_aas);

	always_comb begin
		set_vec = 8'h00;
		set_vec[BIT_RECEIVE_FULL_FLAG] = rx_take; // [RULE19]
		set_vec[BIT_NACK] = ev_nack;
		set_vec[BIT_STOP] = ev_stop;
		set_vec[BIT_AL] = ev_al | ev_ove;
		set_vec[BIT_AAS] = ev_aas;
		set_vec[BIT_ADZ] = ev_adz;
	end

	// Status writes clear only bits armed by an earlier read of 1; a receive read clears bit 5
	always_comb begin
		clr_vec = 8'h00;
		if (wr_status) begin
			clr_vec = armed_reg & ~pwdata[7:0]; // [RULE2]
		end
		if (rd_rx) begin
			clr_vec[BIT_RECEIVE_FULL_FLAG] = 1'b1;
		end
		status_next = (status_reg & ~clr_vec) | set_vec; // [RULE21]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= RST_STATUS;
		end else begin
			status_reg <= status_next;
		end
	end

	// Arming follows status reads, dropped after any status write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_reg <= 8'h00;
		end else if (rd_status) begin
			armed_reg <= prdata_reg[7:0];
		end else if (wr_status) begin
			armed_reg <= 8'h00;
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_address_reg <= RST_OWN;
		end else if (wr_own) begin
			own_address_reg <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_reg <= {3'h0, pwdata[4:0]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transmit_holding_reg <= RST_TX;
		end else if (wr_tx) begin
			transmit_holding_reg <= pwdata[7:0];
		end
	end

	// Pending byte survives a load in the same cycle as a new write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pending_reg <= 1'b0;
		end else if (wr_tx) begin
			tx_pending_reg <= 1'b1; // [RULE13]
		end else if (sif.load && sif.empty) begin
			tx_pending_reg <= 1'b0;
		end
	end

	// Shifter control
	assign sif.load = tx_pending_reg & trs & ~(ack_check_enable & status_reg[BIT_NACK]); // [RULE12] [RULE20]
	assign sif.load_data = bit_order_select ? bit_reverse(transmit_holding_reg) : transmit_holding_reg;
	assign sif.tx_en = trs;
	assign sif.sync_fmt = ~two_wire;
	assign sif.ack_drive_en = two_wire & (mst | addressed_reg);
	assign sif.ack_level = ctrl_reg[CTRL_ACKBT];
	assign sif.restart = (start_det & two_wire) | wr_own;
	assign sif.scl_rise = scl_rise;
	assign sif.scl_fall = scl_fall;
	assign sif.sda_in = sda_s;

	// Receive holding: only the receive path writes it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_holding_reg <= RST_RX;
		end else if (rx_take) begin
			receive_holding_reg <= sif.rx_byte; // [RULE15] [RULE16]
		end
	end

	// Frame tracking after start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_det) begin
						state_reg <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					if (stop_det) begin
						state_reg <= ST_IDLE;
					end else if (sif.byte_done) begin
						state_reg <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (stop_det) begin
						state_reg <= ST_IDLE;
					end else if (start_det) begin
						state_reg <= ST_ADDR;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addressed_reg <= 1'b0;
		end else if (start_det || stop_det) begin
			addressed_reg <= 1'b0;
		end else if (ev_aas) begin
			addressed_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_seen_reg <= 1'b0;
		end else if (stop_det || start_det) begin
			frame_seen_reg <= 1'b0;
		end else if (sif.byte_done) begin
			frame_seen_reg <= 1'b1;
		end
	end

	// Open-drain data pin: pull low for a zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_oe_reg <= 1'b0;
		end else begin
			sda_oe_reg <= sif.drive & ~sif.sda_level; // [RULE17]
		end
	end

	assign sda_oe = sda_oe_reg;
	assign sda_out = 1'b0;

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else if (setup && !pwrite) begin
			if (decode_hit(paddr, OFF_STATUS)) begin
				prdata_reg <= {24'h000000, status_reg};
			end else if (decode_hit(paddr, OFF_OWN)) begin
				prdata_reg <= {24'h000000, own_address_reg};
			end else if (decode_hit(paddr, OFF_TX)) begin
				prdata_reg <= {24'h000000, sif.load_data}; // [RULE14]
			end else if (decode_hit(paddr, OFF_RX)) begin
				prdata_reg <= {24'h000000, receive_holding_reg};
			end else if (decode_hit(paddr, OFF_CTRL)) begin
				prdata_reg <= {24'h000000, ctrl_reg};
			end else begin
				prdata_reg <= '0; // [RULE18]
			end
		end
	end
endmodule // i2c_status_path

// ===== testbench/i2c_bus_model.sv
// Other master or slave on the two-wire bus: clocks frames, drives data.
// Assumes a pulled-up data wire resolved by the bench.
`timescale 1ns/1ps
module i2c_bus_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start_c();
		#13 sda_low = 1'b1;
		#160 scl = 1'b0;
	endtask
	task automatic bit_c(input logic b, output logic r);
		#20 sda_low = ~b;
		#220 scl = 1'b1;
		#60 r = sda;
		#20 scl = 1'b0;
	endtask
	task automatic byte_c(input logic [7:0] d, output logic [7:0] r);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bit_c(d[i], t);
			r[i] = t;
		end
	endtask
	task automatic stop_c();
		#20 sda_low = 1'b1;
		#220 scl = 1'b1;
		#160 sda_low = 1'b0;
		#320;
	endtask
	task automatic low_c();
		#13 scl = 1'b0;
	endtask
	task automatic high_c();
		#20 sda_low = 1'b0;
		#220 scl = 1'b1;
		#320;
	endtask
endmodule // i2c_bus_model

// ===== testbench/i2c_status_path_asserts.sv
// Checker for the status and data path ports.
// Assumes the APB and pin ports of i2c_status_path only; bound below.
`timescale 1ns/1ps
module i2c_status_path_asserts
	import i2c_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc, rd_acc, wr_acc, mls_sh, st_wr;
	logic [7:0] own_sh, tx_sh, tx_rev, st_seen;
	assign acc = psel && penable;
	assign rd_acc = acc && !pwrite;
	assign wr_acc = acc && pwrite;
	assign tx_rev = {<<{tx_sh}};
	// Shadows of written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_sh <= RST_OWN;
			tx_sh <= RST_TX;
			mls_sh <= 1'b0;
		end else if (wr_acc) begin
			if (paddr == OFF_OWN) own_sh <= pwdata[7:0];
			if (paddr == OFF_TX) tx_sh <= pwdata[7:0];
			if (paddr == OFF_CTRL) mls_sh <= pwdata[CTRL_MLS];
		end
	end
	// Last status read and any write since
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_seen <= RST_STATUS;
			st_wr <= 1'b0;
		end else if (wr_acc && paddr == OFF_STATUS) begin
			st_wr <= 1'b1;
		end else if (rd_acc && paddr == OFF_STATUS) begin
			st_seen <= prdata[7:0];
			st_wr <= 1'b0;
		end
	end
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda driven high");
	property p_oe_low; $changed(sda_oe) |-> !scl_in; endproperty
	a_oe_low: assert property (p_oe_low) else $error("sda changed while scl high");
	property p_own; rd_acc && paddr == OFF_OWN |-> prdata[7:0] == own_sh; endproperty
	a_own: assert property (p_own) else $error("own address readback wrong");
	property p_tx;
		rd_acc && paddr == OFF_TX |-> prdata[7:0] == (mls_sh ? tx_rev : tx_sh);
	endproperty
	a_tx: assert property (p_tx) else $error("transmit readback wrong");
	property p_keep;
		rd_acc && paddr == OFF_STATUS && !st_wr |-> (prdata[4:0] & st_seen[4:0]) == st_seen[4:0];
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost without write");
	property p_rx_wr; wr_acc && paddr == OFF_RX |-> !pslverr; endproperty
	a_rx_wr: assert property (p_rx_wr) else $error("receive write refused");
	property p_hi; rd_acc |-> prdata[31:8] == 24'h000000; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_top; rd_acc && paddr == OFF_STATUS |-> prdata[7:6] == 2'b00; endproperty
	a_top: assert property (p_top) else $error("status top bits set");
	property p_unm; acc && paddr > OFF_CTRL |-> pslverr ##1 !pslverr; endproperty
	a_unm: assert property (p_unm) else $error("unmapped access not refused");
	c_match: cover property (rd_acc && paddr == OFF_STATUS && prdata[BIT_AAS]);
	c_oe: cover property ($rose(sda_oe));
	c_unm: cover property (acc && pslverr);
endmodule // i2c_status_path_asserts
bind i2c_status_path i2c_status_path_asserts i2c_status_path_asserts_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// ===== testbench/tb.sv
// Self-checking bench for i2c_status_path.
// Assumes the bus model and the bound checker.
`timescale 1ns/1ps
module tb;
	import i2c_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic sda_out, sda_oe, scl_w, m_low, sda_w, e, ab;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rv;
	logic [7:0] rb;
	int error_cnt = 0;
	int num_checks = 0;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_low;
	i2c_status_path i2c_status_path_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
	i2c_bus_model m (.scl(scl_w), .sda_low(m_low), .sda(sda_w));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task final_report;
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rv & mk, x);
	endtask
	task clr;
		rc(OFF_STATUS, 32'h0, 32'h0);
		rc(OFF_RX, 32'h0, 32'h0);
		wr(OFF_STATUS, 32'h0);
	endtask
	task sf(input logic [7:0] d);
		m.start_c();
		m.byte_c(d, rb);
		m.bit_c(1'b1, ab);
		m.stop_c();
	endtask
	task t_reset;
		rc(OFF_STATUS, ALL, 32'h0);
		rc(OFF_OWN, ALL, 32'h0);
		rc(OFF_TX, ALL, 32'hFF);
		wr(OFF_RX, 32'h55);
		rc(OFF_RX, ALL, 32'hFF);
		apb(1'b0, 8'h14, 32'h0);
		chk({rv[30:0], e}, 32'h1);
	endtask
	task t_slave;
		wr(OFF_OWN, 32'h54);
		wr(OFF_CTRL, 32'h0);
		sf(8'h54);
		chk({31'h0, ab}, 32'h0);
		wr(OFF_STATUS, 32'h0);
		rc(OFF_STATUS, ALL, 32'h2A);
		rc(OFF_RX, ALL, 32'h54);
		wr(OFF_STATUS, 32'h0);
		rc(OFF_STATUS, ALL, 32'h0);
		sf(8'h56);
		chk({31'h0, ab}, 32'h1);
		rc(OFF_STATUS, 32'h3, 32'h0);
		clr;
	endtask
	task t_gcall;
		sf(8'h00);
		rc(OFF_STATUS, 32'h3, 32'h3);
		clr;
		sf(8'h01);
		rc(OFF_STATUS, 32'h3, 32'h0);
		clr;
	endtask
	task t_cont;
		wr(OFF_CTRL, 32'h3);
		wr(OFF_TX, 32'h5A);
		wr(OFF_TX, 32'hC3);
		m.start_c();
		m.byte_c(8'hFF, rb);
		chk({24'h0, rb}, 32'h5A);
		m.bit_c(1'b1, ab);
		m.byte_c(8'hFF, rb);
		chk({24'h0, rb}, 32'hC3);
		m.bit_c(1'b0, ab);
		m.stop_c();
		rc(OFF_STATUS, 32'h10, 32'h0);
		clr;
	endtask
	task t_nack;
		wr(OFF_CTRL, 32'h7);
		wr(OFF_TX, 32'h96);
		m.start_c();
		m.byte_c(8'hFF, rb);
		chk({24'h0, rb}, 32'h96);
		m.bit_c(1'b1, ab);
		repeat (4) @(posedge pclk);
		rc(OFF_STATUS, 32'h10, 32'h10);
		wr(OFF_TX, 32'h33);
		m.byte_c(8'hFF, rb);
		chk({24'h0, rb}, 32'hFF);
		m.bit_c(1'b1, ab);
		m.stop_c();
		clr;
		m.start_c();
		m.byte_c(8'hFF, rb);
		chk({24'h0, rb}, 32'h33);
		m.bit_c(1'b0, ab);
		m.stop_c();
		clr;
	endtask
	task t_arb;
		wr(OFF_CTRL, 32'h3);
		wr(OFF_TX, 32'h40);
		m.start_c();
		m.byte_c(8'hBF, rb);
		m.bit_c(1'b1, ab);
		m.stop_c();
		rc(OFF_STATUS, 32'h4, 32'h4);
		clr;
		wr(OFF_TX, 32'hFF);
		m.low_c();
		m.high_c();
		m.start_c();
		rc(OFF_STATUS, 32'h4, 32'h4);
		m.stop_c();
		clr;
	endtask
	task t_ovr;
		wr(OFF_OWN, 32'h55);
		wr(OFF_CTRL, 32'h0);
		m.low_c();
		m.byte_c(8'h3C, rb);
		m.byte_c(8'hC3, rb);
		m.high_c();
		rc(OFF_STATUS, 32'h24, 32'h24);
		rc(OFF_RX, ALL, 32'hC3);
		clr;
		wr(OFF_OWN, 32'h0);
	endtask
	task t_order;
		wr(OFF_CTRL, 32'h8);
		wr(OFF_TX, 32'h01);
		rc(OFF_TX, ALL, 32'h80);
		wr(OFF_TX, 32'hC4);
		rc(OFF_TX, ALL, 32'h23);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		final_report;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_slave;
		t_gcall;
		t_cont;
		t_nack;
		t_arb;
		t_ovr;
		t_order;
		final_report;
	end
endmodule // tb
